// ==== odec_cfg.svh ====
// Purpose: address map, enable bit positions and timing figures of the decoder
// Assumes: 24-bit byte address, 16-bit extension enable word
// Notes:   definitions only
`ifndef ODEC_CFG_SVH
`define ODEC_CFG_SVH

// ----------------------------------------------------------------------------
// address space
// ----------------------------------------------------------------------------
`define ODEC_ADDR_W          24
`define ODEC_PAGE_W          16
`define ODEC_SEG_W           8
`define ODEC_XRAM_LOW_LO     24'h00E000
`define ODEC_XRAM_LOW_HI     24'h00E7FF
`define ODEC_XRAM_HIGH_RST   8'h09
`define ODEC_FLASH0_LO       24'h000000
`define ODEC_FLASH0_HI       24'h007FFF
`define ODEC_FLASH1_LO       24'h018000
`define ODEC_FLASH1_HI       24'h04FFFF
`define ODEC_TFLASH_HI       24'h001FFF
`define ODEC_FCTRL_LO        24'h080000
`define ODEC_FCTRL_HI        24'h08FFFF
`define ODEC_SFR_LO          24'h00FE00
`define ODEC_SFR_HI          24'h00FFFF
`define ODEC_ESFR_LO         24'h00F000
`define ODEC_ESFR_HI         24'h00F1FF
`define ODEC_EXT_LIMIT_CAN   24'h500000

// ----------------------------------------------------------------------------
// extension peripheral pages (address bits 23:8)
// ----------------------------------------------------------------------------
`define ODEC_PG_CAN1         16'h00EF
`define ODEC_PG_CAN2         16'h00EE
`define ODEC_PG_RTC          16'h00ED
`define ODEC_PG_PWM          16'h00EC
`define ODEC_PG_ASC          16'h00E9
`define ODEC_PG_SSC          16'h00E8
`define ODEC_PG_I2C          16'h00EA
`define ODEC_PG_MISC         16'h00EB

// ----------------------------------------------------------------------------
// bit positions in the extension enable word
// ----------------------------------------------------------------------------
`define ODEC_EN_CAN1         0
`define ODEC_EN_CAN2         1
`define ODEC_EN_XRAM_LOW     2
`define ODEC_EN_XRAM_HIGH    3
`define ODEC_EN_RTC          4
`define ODEC_EN_PWM          6
`define ODEC_EN_ASC          7
`define ODEC_EN_SSC          8
`define ODEC_EN_I2C          9
`define ODEC_EN_MISC         10

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define ODEC_CLK_PERIOD_PS   25000
`define ODEC_XRAM_ACC_PS     31250
`define ODEC_PERIPH_ACC_PS   62500
`define ODEC_XRAM_ACC_CYC    ((`ODEC_XRAM_ACC_PS + `ODEC_CLK_PERIOD_PS - 1) / `ODEC_CLK_PERIOD_PS)
`define ODEC_PERIPH_ACC_CYC  ((`ODEC_PERIPH_ACC_PS + `ODEC_CLK_PERIOD_PS - 1) / `ODEC_CLK_PERIOD_PS)
`define ODEC_WAIT_XRAM       2'h0
`define ODEC_WAIT_PERIPH     2'h2
`define ODEC_WAIT_NONE       2'h0
`define ODEC_CYC_ONE         3'h1

`endif

// ==== odec_pkg.sv ====
// Purpose: shared types of the address decoder
// Assumes: nothing
// Notes:   numbers live in odec_cfg.svh
package odec_pkg;

    // ------------------------------------------------------------------------
    // targets and data path widths
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        ODEC_T_EXT, ODEC_T_FLASH, ODEC_T_TFLASH, ODEC_T_FCTRL, ODEC_T_SFR,
        ODEC_T_XRAM_LOW, ODEC_T_XRAM_HIGH, ODEC_T_CAN1, ODEC_T_CAN2, ODEC_T_RTC,
        ODEC_T_PWM, ODEC_T_ASC, ODEC_T_SSC, ODEC_T_I2C, ODEC_T_MISC
    } odec_target_e;

    typedef enum logic {
        ODEC_W16, ODEC_W32
    } odec_width_e;

endpackage

// ==== odec_periph_decode.sv ====
// Purpose: match an address against the extension peripheral windows
// Assumes: each window is one 256-byte page
// Notes:   hit order is can1, can2, rtc, pwm, asc, ssc, i2c, misc
`include "odec_cfg.svh"

module odec_periph_decode (
    // address and enables
    input  wire logic [`ODEC_ADDR_W-1:0] addr,
    input  wire logic                    glob_en,
    input  wire logic [15:0]             pen,
    // one bit per window
    output logic      [7:0]              hit
);
    localparam logic [`ODEC_PAGE_W-1:0] PAGE [8] = '{
        `ODEC_PG_CAN1, `ODEC_PG_CAN2, `ODEC_PG_RTC, `ODEC_PG_PWM,
        `ODEC_PG_ASC, `ODEC_PG_SSC, `ODEC_PG_I2C, `ODEC_PG_MISC};
    localparam int ENB [8] = '{
        `ODEC_EN_CAN1, `ODEC_EN_CAN2, `ODEC_EN_RTC, `ODEC_EN_PWM,
        `ODEC_EN_ASC, `ODEC_EN_SSC, `ODEC_EN_I2C, `ODEC_EN_MISC};

    // a cleared enable leaves the page to the external bus
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            hit[i] = glob_en && pen[ENB[i]]
                     && (addr[`ODEC_ADDR_W-1:8] == PAGE[i]);
        end
    end
endmodule

// ==== odec_attr.sv ====
// Purpose: access attributes of the selected target
// Assumes: target already decoded
// Notes:   external cycles take their timing from the bus controller
`include "odec_cfg.svh"

module odec_attr (
    // selection
    input  wire odec_pkg::odec_target_e tgt,
    input  wire logic                   fetch,
    // attributes
    output odec_pkg::odec_width_e       width,
    output logic [1:0]                  wait_st,
    output logic [2:0]                  cycles,
    output logic                        word_only
);
    // peripherals: 16 bit, two waits, word only; xram: no waits
    always_comb begin
        width     = odec_pkg::ODEC_W16;
        wait_st   = `ODEC_WAIT_NONE;
        cycles    = `ODEC_CYC_ONE;
        word_only = 1'b0;
        case (tgt)
            odec_pkg::ODEC_T_FLASH, odec_pkg::ODEC_T_TFLASH: begin
                width = fetch ? odec_pkg::ODEC_W32 : odec_pkg::ODEC_W16;
            end
            odec_pkg::ODEC_T_XRAM_LOW, odec_pkg::ODEC_T_XRAM_HIGH: begin
                wait_st = `ODEC_WAIT_XRAM;
                cycles  = 3'(`ODEC_XRAM_ACC_CYC);
            end
            odec_pkg::ODEC_T_CAN1, odec_pkg::ODEC_T_CAN2, odec_pkg::ODEC_T_RTC,
            odec_pkg::ODEC_T_PWM, odec_pkg::ODEC_T_ASC, odec_pkg::ODEC_T_SSC,
            odec_pkg::ODEC_T_I2C, odec_pkg::ODEC_T_MISC: begin
                wait_st   = `ODEC_WAIT_PERIPH;
                cycles    = 3'(`ODEC_PERIPH_ACC_CYC);
                word_only = 1'b1;
            end
            default: ;
        endcase
    end
endmodule

// ==== odec_top.sv ====
// Purpose: steer each cpu access in the 16 MB space to exactly one target
// Assumes: one request per cycle, answer one cycle later
// Notes:   boot strap pin is synchronised, config inputs are same-clock
//
// Behaviour
// - one linear 16 MB space, byte and word
// - low xram at E000-E7FF when both enabled
// - low xram disabled goes to external bus
// - high xram at programmed window when enabled
// - global enable clear sends high window external
// - high xram resets at 09'0000, mirrored 16 KB
// - xram zero waits, byte and word allowed
// - xram not bit addressable, no stack there
// - can1 page EF00 with enable bit 0
// - can2 page EE00 with enable bit 1
// - rtc page ED00 with enable bit 4
// - pwm page EC00 with enable bit 6
// - async serial page E900 with bit 7
// - sync serial page E800 with bit 8
// - i2c page EA00 with enable bit 9
// - misc page EB00 with enable bit 10
// - peripherals word only, 16 bit, two waits
// - can in use limits external to 5 MB
// - disabled peripheral claims no address space
// - test flash at zero only in boot
// - flash fetch 32 bit, control 16 bit
// - two 512-byte register areas reserved
`include "odec_cfg.svh"

module odec_top (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rstn,
    // cpu request
    input  wire logic                    req_valid,
    input  wire logic [`ODEC_ADDR_W-1:0] req_addr,
    input  wire logic                    req_write,
    input  wire logic                    req_byte,
    input  wire logic                    req_fetch,
    input  wire logic                    req_bit,
    input  wire logic                    req_stack,
    // configuration
    input  wire logic                    ext_periph_global_enable,
    input  wire logic [15:0]             ext_periph_enable_reg,
    input  wire logic                    xram_high_sel_we,
    input  wire logic [`ODEC_SEG_W-1:0]  xram_high_sel_wdata,
    // strap pin
    input  wire logic                    boot_mode_pin,
    // decode result
    output logic                         sel_valid_r,
    output odec_pkg::odec_target_e       sel_target_r,
    output logic                         sel_write_r,
    output odec_pkg::odec_width_e        sel_width_r,
    output logic [1:0]                   sel_wait_r,
    output logic [2:0]                   sel_cycles_r,
    output logic                         sel_ext_r,
    output logic                         size_err_r,
    output logic                         usage_err_r,
    output logic                         ext_range_err_r,
    // status
    output logic                         seg_lines4_r,
    output logic [`ODEC_SEG_W-1:0]       xram_high_window_select
);
    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic in_rng(input logic [`ODEC_ADDR_W-1:0] a,
                                    input logic [`ODEC_ADDR_W-1:0] lo,
                                    input logic [`ODEC_ADDR_W-1:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    logic                   boot_q1_r;
    logic                   boot_q2_r;
    logic [7:0]             phit;
    logic                   glob;
    logic                   xlow_hit;
    logic                   xhigh_hit;
    logic                   can_used;
    odec_pkg::odec_target_e tgt_nxt;
    odec_pkg::odec_width_e  width_c;
    logic [1:0]             wait_c;
    logic [2:0]             cycles_c;
    logic                   word_only_c;

    // ------------------------------------------------------------------------
    // strap synchroniser
    // ------------------------------------------------------------------------
    // the pin is asynchronous; only the second stage is read
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            boot_q1_r <= 1'b0;
            boot_q2_r <= 1'b0;
        end else begin
            boot_q1_r <= boot_mode_pin;
            boot_q2_r <= boot_q1_r;
        end
    end

    // ------------------------------------------------------------------------
    // high xram window select
    // ------------------------------------------------------------------------
    // holds address bits 23:16 of the window
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            xram_high_window_select <= `ODEC_XRAM_HIGH_RST;
        end else if (xram_high_sel_we) begin
            xram_high_window_select <= xram_high_sel_wdata;
        end
    end

    // ------------------------------------------------------------------------
    // window matching
    // ------------------------------------------------------------------------
    assign glob = ext_periph_global_enable;

    odec_periph_decode u_periph (
        .addr    (req_addr),
        .glob_en (glob),
        .pen     (ext_periph_enable_reg),
        .hit     (phit)
    );

    // both enables needed; otherwise the range falls through
    assign xlow_hit = glob && ext_periph_enable_reg[`ODEC_EN_XRAM_LOW]
                      && in_rng(req_addr, `ODEC_XRAM_LOW_LO, `ODEC_XRAM_LOW_HI);
    // the whole 64 KB window answers, so the 16 KB array mirrors in it
    assign xhigh_hit = glob && ext_periph_enable_reg[`ODEC_EN_XRAM_HIGH]
                       && (req_addr[`ODEC_ADDR_W-1:`ODEC_PAGE_W]
                           == xram_high_window_select);
    assign can_used = glob && (ext_periph_enable_reg[`ODEC_EN_CAN1]
                               || ext_periph_enable_reg[`ODEC_EN_CAN2]);

    // ------------------------------------------------------------------------
    // target priority
    // ------------------------------------------------------------------------
    // fixed on-chip areas first, so a badly placed high window cannot
    // shadow flash or registers; anything left goes external
    always_comb begin
        tgt_nxt = odec_pkg::ODEC_T_EXT;
        if (boot_q2_r && in_rng(req_addr, `ODEC_FLASH0_LO, `ODEC_TFLASH_HI)) begin
            tgt_nxt = odec_pkg::ODEC_T_TFLASH;
        end else if (in_rng(req_addr, `ODEC_FLASH0_LO, `ODEC_FLASH0_HI)
                     || in_rng(req_addr, `ODEC_FLASH1_LO, `ODEC_FLASH1_HI)) begin
            tgt_nxt = odec_pkg::ODEC_T_FLASH;
        end else if (in_rng(req_addr, `ODEC_FCTRL_LO, `ODEC_FCTRL_HI)) begin
            tgt_nxt = odec_pkg::ODEC_T_FCTRL;
        end else if (in_rng(req_addr, `ODEC_SFR_LO, `ODEC_SFR_HI)
                     || in_rng(req_addr, `ODEC_ESFR_LO, `ODEC_ESFR_HI)) begin
            tgt_nxt = odec_pkg::ODEC_T_SFR;
        end else if (xlow_hit) begin
            tgt_nxt = odec_pkg::ODEC_T_XRAM_LOW;
        end else if (phit[0]) begin
            tgt_nxt = odec_pkg::ODEC_T_CAN1;
        end else if (phit[1]) begin
            tgt_nxt = odec_pkg::ODEC_T_CAN2;
        end else if (phit[2]) begin
            tgt_nxt = odec_pkg::ODEC_T_RTC;
        end else if (phit[3]) begin
            tgt_nxt = odec_pkg::ODEC_T_PWM;
        end else if (phit[4]) begin
            tgt_nxt = odec_pkg::ODEC_T_ASC;
        end else if (phit[5]) begin
            tgt_nxt = odec_pkg::ODEC_T_SSC;
        end else if (phit[6]) begin
            tgt_nxt = odec_pkg::ODEC_T_I2C;
        end else if (phit[7]) begin
            tgt_nxt = odec_pkg::ODEC_T_MISC;
        end else if (xhigh_hit) begin
            tgt_nxt = odec_pkg::ODEC_T_XRAM_HIGH;
        end
    end

    odec_attr u_attr (
        .tgt       (tgt_nxt),
        .fetch     (req_fetch),
        .width     (width_c),
        .wait_st   (wait_c),
        .cycles    (cycles_c),
        .word_only (word_only_c)
    );

    // ------------------------------------------------------------------------
    // registered decode result
    // ------------------------------------------------------------------------
    // every address decodes, byte and word alike, one cycle later
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sel_valid_r  <= 1'b0;
            sel_target_r <= odec_pkg::ODEC_T_EXT;
            sel_write_r  <= 1'b0;
            sel_width_r  <= odec_pkg::ODEC_W16;
            sel_wait_r   <= `ODEC_WAIT_NONE;
            sel_cycles_r <= `ODEC_CYC_ONE;
            sel_ext_r    <= 1'b0;
        end else begin
            sel_valid_r  <= req_valid;
            sel_target_r <= tgt_nxt;
            sel_write_r  <= req_write;
            sel_width_r  <= width_c;
            sel_wait_r   <= wait_c;
            sel_cycles_r <= cycles_c;
            sel_ext_r    <= req_valid && (tgt_nxt == odec_pkg::ODEC_T_EXT);
        end
    end

    // ------------------------------------------------------------------------
    // access errors
    // ------------------------------------------------------------------------
    // errors only flag; stopping the cycle is the bus controller's job
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            size_err_r      <= 1'b0;
            usage_err_r     <= 1'b0;
            ext_range_err_r <= 1'b0;
        end else begin
            size_err_r      <= req_valid && req_byte && word_only_c;
            usage_err_r     <= req_valid && (req_bit || req_stack)
                               && (tgt_nxt == odec_pkg::ODEC_T_XRAM_LOW
                                   || tgt_nxt == odec_pkg::ODEC_T_XRAM_HIGH);
            ext_range_err_r <= req_valid && can_used
                               && (tgt_nxt == odec_pkg::ODEC_T_EXT)
                               && (req_addr >= `ODEC_EXT_LIMIT_CAN);
        end
    end

    // ------------------------------------------------------------------------
    // segment line status
    // ------------------------------------------------------------------------
    // can pins take the upper segment lines away
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            seg_lines4_r <= 1'b0;
        end else begin
            seg_lines4_r <= can_used;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // low xram hit
    xram_low_win_a: assert property (
        req_valid && glob && ext_periph_enable_reg[`ODEC_EN_XRAM_LOW]
        && in_rng(req_addr, `ODEC_XRAM_LOW_LO, `ODEC_XRAM_LOW_HI)
        |=> sel_target_r == odec_pkg::ODEC_T_XRAM_LOW && sel_wait_r == `ODEC_WAIT_XRAM)
        else $error("low xram window not selected");

    // low xram off
    xram_low_off_a: assert property (
        req_valid && !(glob && ext_periph_enable_reg[`ODEC_EN_XRAM_LOW])
        && in_rng(req_addr, `ODEC_XRAM_LOW_LO, `ODEC_XRAM_LOW_HI)
        |=> sel_ext_r && sel_target_r == odec_pkg::ODEC_T_EXT)
        else $error("disabled low xram not sent external");

    // high, global off
    xram_high_off_a: assert property (
        req_valid && !glob && req_addr[`ODEC_ADDR_W-1:`ODEC_PAGE_W] == xram_high_window_select
        && !in_rng(req_addr, `ODEC_FLASH0_LO, `ODEC_FCTRL_HI)
        |=> sel_ext_r)
        else $error("high window with global enable clear not external");

    // reset window
    xram_high_rst_a: assert property (
        $rose(rstn) |-> xram_high_window_select == `ODEC_XRAM_HIGH_RST)
        else $error("high window select not at reset value");

    // can1 page
    can1_win_a: assert property (
        req_valid && glob && ext_periph_enable_reg[`ODEC_EN_CAN1]
        && req_addr[`ODEC_ADDR_W-1:8] == `ODEC_PG_CAN1
        |=> sel_target_r == odec_pkg::ODEC_T_CAN1 && sel_wait_r == `ODEC_WAIT_PERIPH)
        else $error("can1 page not selected with two waits");

    // misc page
    misc_win_a: assert property (
        req_valid && glob && ext_periph_enable_reg[`ODEC_EN_MISC]
        && req_addr[`ODEC_ADDR_W-1:8] == `ODEC_PG_MISC
        |=> sel_target_r == odec_pkg::ODEC_T_MISC)
        else $error("misc page not selected");

    // hidden page
    periph_hidden_a: assert property (
        req_valid && glob && !ext_periph_enable_reg[`ODEC_EN_RTC]
        && req_addr[`ODEC_ADDR_W-1:8] == `ODEC_PG_RTC
        |=> sel_ext_r)
        else $error("disabled rtc still claims its page");

    // byte to page
    periph_byte_a: assert property (
        req_valid && req_byte && glob && ext_periph_enable_reg[`ODEC_EN_I2C]
        && req_addr[`ODEC_ADDR_W-1:8] == `ODEC_PG_I2C
        |=> size_err_r && sel_width_r == odec_pkg::ODEC_W16)
        else $error("byte access to peripheral not flagged");

    // seg lines
    seg_lines_a: assert property (
        glob && ext_periph_enable_reg[`ODEC_EN_CAN2] |=> seg_lines4_r)
        else $error("segment lines not limited with can in use");

    // boot flash
    boot_flash_a: assert property (
        req_valid && in_rng(req_addr, `ODEC_FLASH0_LO, `ODEC_TFLASH_HI)
        |=> sel_target_r == ($past(boot_q2_r) ? odec_pkg::ODEC_T_TFLASH
                                              : odec_pkg::ODEC_T_FLASH))
        else $error("low flash block mapped to the wrong flash");

    // fetch width
    flash_fetch_a: assert property (
        req_valid && req_fetch && in_rng(req_addr, `ODEC_FLASH1_LO, `ODEC_FLASH1_HI)
        |=> sel_width_r == odec_pkg::ODEC_W32)
        else $error("flash fetch not 32 bit");

    // xram bit use
    xram_bit_a: assert property (
        sel_target_r == odec_pkg::ODEC_T_XRAM_HIGH && sel_valid_r
        && $past(req_bit) |-> usage_err_r)
        else $error("bit access to xram not flagged");

    // ext strobe
    ext_valid_a: assert property (
        sel_ext_r |-> sel_valid_r && sel_target_r == odec_pkg::ODEC_T_EXT)
        else $error("external strobe without external target");

    // high xram hit
    xram_high_win_a: assert property (
        req_valid && glob && ext_periph_enable_reg[`ODEC_EN_XRAM_HIGH]
        && req_addr[`ODEC_ADDR_W-1:`ODEC_PAGE_W] == xram_high_window_select
        && !in_rng(req_addr, `ODEC_FLASH0_LO, `ODEC_FCTRL_HI)
        |=> sel_target_r == odec_pkg::ODEC_T_XRAM_HIGH && sel_wait_r == `ODEC_WAIT_XRAM)
        else $error("high xram window not selected");

    // can2 page
    can2_win_a: assert property (
        req_valid && glob && ext_periph_enable_reg[`ODEC_EN_CAN2]
        && req_addr[`ODEC_ADDR_W-1:8] == `ODEC_PG_CAN2
        |=> sel_target_r == odec_pkg::ODEC_T_CAN2 && sel_cycles_r == 3'(`ODEC_PERIPH_ACC_CYC))
        else $error("can2 page not selected");

    // main scenarios
    cov_xram_high_c: cover property (sel_valid_r && sel_target_r == odec_pkg::ODEC_T_XRAM_HIGH);
    cov_can2_c:      cover property (sel_valid_r && sel_target_r == odec_pkg::ODEC_T_CAN2);
    cov_tflash_c:    cover property (sel_valid_r && sel_target_r == odec_pkg::ODEC_T_TFLASH);
    cov_rng_err_c:   cover property (ext_range_err_r);
    cov_size_err_c:  cover property (size_err_r);
endmodule

// ==== odec_cpu_model.sv ====
// Purpose: cpu side model issuing one access per cycle
// Assumes: the caller acts at the falling edge of mclk
// Notes:   bit and stack flags only when a scenario asks for them
module odec_cpu_model (
    // request to the decoder
    output logic        req_valid,
    output logic [23:0] req_addr,
    output logic [4:0]  req_fl
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle at time zero so nothing is taken during reset
    initial begin
        req_valid = 1'b0;
        req_addr  = 24'h000000;
        req_fl    = 5'h00;
    end
    // flags are {write, byte, fetch, bit, stack}; stack in xram only on purpose
    task automatic put(input logic v, input logic [23:0] a, input logic [4:0] f);
        req_valid = v;
        req_addr  = a;
        req_fl    = f;
    endtask
endmodule

// ==== onchip_address_decoder_tb.sv ====
// Purpose: corner and random accesses checked against the address map
// Assumes: config inputs change together with each request
// Notes:   one answer per request, compared one cycle later
module onchip_address_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk  = 1'b0;
    logic        rstn  = 1'b0;
    logic        g     = 1'b0;
    logic        we    = 1'b0;
    logic        boot  = 1'b0;
    logic        bt_m  = 1'b0;
    logic        pend  = 1'b0;
    logic [15:0] pen   = 16'h0000;
    logic [15:0] rs    = 16'h004F;
    logic [15:0] r1, r2, r3;
    logic [7:0]  wd    = 8'h00;
    logic [7:0]  sel_m = 8'h09;
    logic [7:0]  segs [8] = '{8'h00, 8'h00, 8'h03, 8'h09, 8'h08, 8'h05, 8'h60, 8'h09};
    logic [23:0] cor [17] = '{24'h00E000, 24'h00E7FF, 24'h00E800, 24'h00EFFF,
        24'h00ED10, 24'h00EC00, 24'h00E9FE, 24'h00EAFF, 24'h00EB50, 24'h093FFF,
        24'h094000, 24'h500000, 24'h4FFFFF, 24'h00F1FF, 24'h00FE00, 24'h080000, 24'h00EE80};
    logic [16:0] exp_q;
    int          fails = 0;
    int          tests_run = 0;
    wire  [16:0] got;
    wire  [7:0]  hws;
    wire         pv;
    wire  [23:0] pa;
    wire  [4:0]  pf;
    // clock: 40 MHz
    always #12.5 mclk = ~mclk;
    odec_cpu_model u_cpu (.req_valid(pv), .req_addr(pa), .req_fl(pf));
    odec_top u_dut (.mclk(mclk), .rstn(rstn), .req_valid(pv), .req_addr(pa),
        .req_write(pf[4]), .req_byte(pf[3]), .req_fetch(pf[2]), .req_bit(pf[1]),
        .req_stack(pf[0]), .ext_periph_global_enable(g), .ext_periph_enable_reg(pen),
        .xram_high_sel_we(we), .xram_high_sel_wdata(wd), .boot_mode_pin(boot),
        .sel_valid_r(got[16]), .sel_target_r(got[15:12]), .sel_write_r(got[11]),
        .sel_width_r(got[10]), .sel_wait_r(got[9:8]), .sel_cycles_r(got[7:5]),
        .sel_ext_r(got[4]), .size_err_r(got[3]), .usage_err_r(got[2]),
        .ext_range_err_r(got[1]), .seg_lines4_r(got[0]), .xram_high_window_select(hws));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected answer; later tests override earlier, highest priority last
    function automatic logic [16:0] exp_of(input logic [23:0] a, input logic [4:0] f,
            input logic gl, input logic [15:0] p, input logic bm, input logic [7:0] hs);
        odec_pkg::odec_target_e t;
        logic pr;
        logic xr;
        logic c;
        logic e;
        t = odec_pkg::ODEC_T_EXT;
        if (gl && p[3] && a[23:16] == hs) t = odec_pkg::ODEC_T_XRAM_HIGH;
        if (gl) case (a[23:8])
            16'h00EF: if (p[0]) t = odec_pkg::ODEC_T_CAN1;
            16'h00EE: if (p[1]) t = odec_pkg::ODEC_T_CAN2;
            16'h00ED: if (p[4]) t = odec_pkg::ODEC_T_RTC;
            16'h00EC: if (p[6]) t = odec_pkg::ODEC_T_PWM;
            16'h00E9: if (p[7]) t = odec_pkg::ODEC_T_ASC;
            16'h00E8: if (p[8]) t = odec_pkg::ODEC_T_SSC;
            16'h00EA: if (p[9]) t = odec_pkg::ODEC_T_I2C;
            16'h00EB: if (p[10]) t = odec_pkg::ODEC_T_MISC;
            default: ;
        endcase
        if (gl && p[2] && a >= 24'h00E000 && a <= 24'h00E7FF) t = odec_pkg::ODEC_T_XRAM_LOW;
        if ((a >= 24'h00FE00 && a <= 24'h00FFFF) || (a >= 24'h00F000 && a <= 24'h00F1FF))
            t = odec_pkg::ODEC_T_SFR;
        if (a[23:16] == 8'h08) t = odec_pkg::ODEC_T_FCTRL;
        if (a <= 24'h007FFF || (a >= 24'h018000 && a <= 24'h04FFFF)) t = odec_pkg::ODEC_T_FLASH;
        if (bm && a <= 24'h001FFF) t = odec_pkg::ODEC_T_TFLASH;
        pr = (t >= odec_pkg::ODEC_T_CAN1);
        xr = (t == odec_pkg::ODEC_T_XRAM_LOW) || (t == odec_pkg::ODEC_T_XRAM_HIGH);
        c  = gl & (p[0] | p[1]);
        e  = (t == odec_pkg::ODEC_T_EXT);
        return {1'b1, t, f[4], f[2] & (t == odec_pkg::ODEC_T_FLASH || t == odec_pkg::ODEC_T_TFLASH),
            pr ? 2'h2 : 2'h0, pr ? 3'h3 : (xr ? 3'h2 : 3'h1), e, pr & f[3],
            xr & (f[1] | f[0]), e & c & (a >= 24'h500000), c};
    endfunction
    task automatic check(input logic [16:0] gv, input logic [16:0] ev);
        tests_run++;
        if (gv !== ev) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, gv, ev);
        end
    endtask
    // falling edge: judge the answer to the previous request
    task automatic settle();
        @(negedge mclk);
        if (pend) check(got, exp_q);
    endtask
    task automatic acc(input logic [23:0] a, input logic [4:0] f, input logic gl,
            input logic [15:0] p);
        settle();
        u_cpu.put(1'b1, a, f);
        g     = gl;
        pen   = p;
        exp_q = exp_of(a, f, gl, p, bt_m, sel_m);
        pend  = 1'b1;
    endtask
    task automatic idle();
        settle();
        u_cpu.put(1'b0, 24'h000000, 5'h00);
        we   = 1'b0;
        pend = 1'b0;
    endtask
    task automatic wsel(input logic [7:0] v);
        idle();
        we       = 1'b1;
        wd       = v;
        sel_m    = v;
        segs[7]  = v;
        idle();
        check({9'h000, hws}, {9'h000, v});
    endtask
    task automatic rnd(input int n);
        for (int i = 0; i < n; i++) begin
            r1 = lfsr(rs);
            r2 = lfsr(r1);
            r3 = lfsr(r2);
            rs = r3;
            acc({segs[r1[2:0]], r1[3] ? {4'hE, r1[7:4]} : r2[15:8], r2[7:0]}, {r1[10],
                r1[11], r1[12], r1[13] & r1[14], r1[15] & r1[14]}, r1[8] | r1[9], r3);
        end
        idle();
        $display("random block of %0d done", n);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge mclk);
        rstn = 1'b1;
        idle();
        check({9'h000, hws}, {9'h000, 8'h09});
        // enabled, byte with bit and stack, global off, peripherals off
        for (int k = 0; k < 4; k++) begin
            foreach (cor[i]) acc(cor[i], (k == 1) ? 5'h0B : 5'h14, k != 2,
                (k == 3) ? 16'h0000 : 16'hFFFF);
        end
        idle();
        $display("corner block done");
        wsel(8'h0A);
        acc(24'h0A1234, 5'h00, 1'b1, 16'h0008);
        rnd(400);
        boot = 1'b1;
        repeat (3) idle();
        bt_m = 1'b1;
        acc(24'h001FFE, 5'h04, 1'b1, 16'hFFFF);
        wsel(8'h09);
        $display("boot block done");
        rnd(400);
        print_verdict();
    end
endmodule
